/* verilog/adcce_pkg.sv */
// package: register map, field layouts and types for the channel enables
package adcce_pkg;

  // register indexes; byte address is four times the index
  localparam logic [9:0] ADCCE_IDX_CELL = 10'h109;
  localparam logic [9:0] ADCCE_IDX_AUX_A = 10'h10A;
  localparam logic [9:0] ADCCE_IDX_AUX_B = 10'h10B;
  localparam logic [9:0] ADCCE_IDX_AUX_C = 10'h10C;
  localparam logic [9:0] ADCCE_IDX_STATUS = 10'h1F0;

  // widths of the cell and aux c fields
  localparam int ADCCE_CELL_W = 6;
  localparam int ADCCE_AUX_C_W = 4;

  // reset values
  localparam logic [5:0] ADCCE_CELL_RST = 6'h00;
  localparam logic [7:0] ADCCE_AUX_AB_RST = 8'h00;
  localparam logic [3:0] ADCCE_AUX_C_RST = 4'h0;

  // status register field positions
  localparam int ADCCE_STAT_CNT_LSB = 0;
  localparam int ADCCE_STAT_AUX_BIT = 4;

  // ahb encodings
  localparam logic [1:0] ADCCE_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ADCCE_HSIZE_WORD = 3'h2;
  localparam logic ADCCE_HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic aux_pin_four_select;
    logic aux_pin_three_select;
    logic aux_pin_two_select;
    logic aux_pin_one_select;
    logic analog_rail_select;
    logic zero_ref_select;
    logic bandgap_one_select;
    logic battery_input_select;
  } adcce_aux_a_t;

  typedef struct packed {
    logic thermal_warning_current_select;
    logic cold_threshold_select;
    logic hot_threshold_select;
    logic low_volt_threshold_select;
    logic high_volt_threshold_select;
    logic bandgap_two_select;
    logic aux_pin_six_select;
    logic aux_pin_five_select;
  } adcce_aux_b_t;

  typedef struct packed {
    logic always_on_reference_select;
    logic comm_rail_select;
    logic thermistor_supply_select;
    logic digital_rail_select;
  } adcce_aux_c_t;

  typedef struct packed {
    logic [5:0] convert_on;
    logic [5:0] shifter_on;
  } adcce_cell_t;

endpackage

/* verilog/adcce_regs.sv */
// channel-enable register bank with its ahb-lite slave port
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
module adcce_regs
  import adcce_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output adcce_pkg::adcce_cell_t cell_sel,
  output adcce_pkg::adcce_aux_a_t aux_sel_a,
  output adcce_pkg::adcce_aux_b_t aux_sel_b,
  output adcce_pkg::adcce_aux_c_t aux_sel_c
);
  import adcce_pkg::*;

  if (ADDR_W < 12)
  begin : g_addr_check
    $error("adcce_regs: ADDR_W must be at least 12");
  end

  logic [5:0] cell_reg;
  logic [5:0] cell_next;
  logic [5:0] shifter_reg;
  logic [7:0] aux_a_reg;
  logic [7:0] aux_a_next;
  logic [7:0] aux_b_reg;
  logic [7:0] aux_b_next;
  logic [3:0] aux_c_reg;
  logic [3:0] aux_c_next;
  logic wr_pend_reg;
  logic [9:0] wr_idx_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ready_reg;
  logic hresp_reg;
  logic addr_take;
  logic [9:0] addr_idx;
  logic [2:0] cell_count;
  logic [7:0] status_val;

  // a transfer is taken only when the bus is ready and it targets us
  assign addr_take = hsel && hready && htrans[1];
  assign addr_idx = haddr[11:2];

  // bus slave: zero wait states, so hreadyout only rises after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ready_reg <= 1'b0;
      hresp_reg <= ADCCE_HRESP_OKAY;
    end
    else
    begin
      ready_reg <= 1'b1;
      hresp_reg <= ADCCE_HRESP_OKAY;
    end
  end

  // sub-word writes are ignored so no byte lane can half-update a field
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 10'h000;
    end
    else if (hready)
    begin
      wr_pend_reg <= addr_take && hwrite && (hsize == ADCCE_HSIZE_WORD);
      wr_idx_reg <= addr_idx;
    end
  end

  // next values from the data phase of a write
  always_comb
  begin
    cell_next = cell_reg;
    aux_a_next = aux_a_reg;
    aux_b_next = aux_b_reg;
    aux_c_next = aux_c_reg;
    if (wr_pend_reg)
    begin
      case (wr_idx_reg)
        ADCCE_IDX_CELL: cell_next = hwdata[5:0];
        ADCCE_IDX_AUX_A: aux_a_next = hwdata[7:0];
        ADCCE_IDX_AUX_B: aux_b_next = hwdata[7:0];
        ADCCE_IDX_AUX_C: aux_c_next = hwdata[3:0];
        default: cell_next = cell_reg;
      endcase
    end
  end

  // cell enables; the shifter copy keeps both outputs flop-driven
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cell_reg <= ADCCE_CELL_RST;
      shifter_reg <= ADCCE_CELL_RST;
    end
    else
    begin
      cell_reg <= cell_next;
      shifter_reg <= cell_next;
    end
  end

  // auxiliary selections
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aux_a_reg <= ADCCE_AUX_AB_RST;
      aux_b_reg <= ADCCE_AUX_AB_RST;
      aux_c_reg <= ADCCE_AUX_C_RST;
    end
    else
    begin
      aux_a_reg <= aux_a_next;
      aux_b_reg <= aux_b_next;
      aux_c_reg <= aux_c_next;
    end
  end

  // number of enabled cells, shown in the status register
  always_comb
  begin
    cell_count = 3'h0;
    for (int i = 0; i < ADCCE_CELL_W; i++)
      cell_count = cell_count + {2'h0, cell_next[i]};
  end

  always_comb
  begin
    status_val = 8'h00;
    status_val[ADCCE_STAT_CNT_LSB +: 3] = cell_count;
    status_val[ADCCE_STAT_AUX_BIT] = |{aux_a_next, aux_b_next, aux_c_next};
  end

  // read mux looks at next values so a read right after a write is fresh
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (addr_idx)
      ADCCE_IDX_CELL: rdata_next[5:0] = cell_next;
      ADCCE_IDX_AUX_A: rdata_next[7:0] = aux_a_next;
      ADCCE_IDX_AUX_B: rdata_next[7:0] = aux_b_next;
      ADCCE_IDX_AUX_C: rdata_next[3:0] = aux_c_next;
      ADCCE_IDX_STATUS: rdata_next[7:0] = status_val;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_reg <= 32'h0000_0000;
    else if (addr_take && !hwrite)
      rdata_reg <= rdata_next;
  end

  assign hreadyout = ready_reg;
  assign hrdata = rdata_reg;
  assign hresp = hresp_reg;
  // one driver for the whole struct: convert_on is the upper half
  assign cell_sel = {cell_reg, shifter_reg};
  assign aux_sel_a = adcce_aux_a_t'(aux_a_reg);
  assign aux_sel_b = adcce_aux_b_t'(aux_b_reg);
  assign aux_sel_c = adcce_aux_c_t'(aux_c_reg);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic wr_cell;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  assign wr_cell = wr_pend_reg && (wr_idx_reg == ADCCE_IDX_CELL);
  assign wr_a = wr_pend_reg && (wr_idx_reg == ADCCE_IDX_AUX_A);
  assign wr_b = wr_pend_reg && (wr_idx_reg == ADCCE_IDX_AUX_B);
  assign wr_c = wr_pend_reg && (wr_idx_reg == ADCCE_IDX_AUX_C);

  property p_cell_write;
    wr_cell |=> (cell_sel.convert_on == $past(hwdata[5:0]))
      && (cell_sel.shifter_on == cell_sel.convert_on);
  endproperty
  a_cell_write: assert property (p_cell_write)
    else $error("cell enables or shifters not taken from write");

  property p_pins_a;
    wr_a |=> {aux_sel_a.aux_pin_four_select, aux_sel_a.aux_pin_three_select,
      aux_sel_a.aux_pin_two_select, aux_sel_a.aux_pin_one_select}
      == $past(hwdata[7:4]);
  endproperty
  a_pins_a: assert property (p_pins_a)
    else $error("pin selects one to four wrong after write");

  property p_rails_a;
    wr_a |=> (aux_sel_a.analog_rail_select == $past(hwdata[3]))
      && (aux_sel_a.battery_input_select == $past(hwdata[0]));
  endproperty
  a_rails_a: assert property (p_rails_a)
    else $error("analog rail or battery select wrong");

  property p_zero_ref;
    wr_a |=> aux_sel_a.zero_ref_select == $past(hwdata[2]);
  endproperty
  a_zero_ref: assert property (p_zero_ref)
    else $error("zero-volt reference select not held");

  property p_bandgap_one;
    wr_a |=> aux_sel_a.bandgap_one_select == $past(hwdata[1]);
  endproperty
  a_bandgap_one: assert property (p_bandgap_one)
    else $error("first bandgap select wrong");

  property p_pins_b;
    wr_b |=> (aux_sel_b.aux_pin_five_select == $past(hwdata[0]))
      && (aux_sel_b.aux_pin_six_select == $past(hwdata[1]));
  endproperty
  a_pins_b: assert property (p_pins_b)
    else $error("pin five or six select wrong");

  property p_bandgap_two;
    wr_b |=> aux_sel_b.bandgap_two_select == $past(hwdata[2]);
  endproperty
  a_bandgap_two: assert property (p_bandgap_two)
    else $error("second bandgap select wrong");

  property p_temp_thresh;
    wr_b |=> (aux_sel_b.cold_threshold_select == $past(hwdata[6]))
      && (aux_sel_b.hot_threshold_select == $past(hwdata[5]));
  endproperty
  a_temp_thresh: assert property (p_temp_thresh)
    else $error("temperature threshold select wrong");

  property p_warn_current;
    wr_b |=> aux_sel_b.thermal_warning_current_select == $past(hwdata[7]);
  endproperty
  a_warn_current: assert property (p_warn_current)
    else $error("thermal warning current select wrong");

  property p_rails_c;
    wr_c |=> (aux_sel_c.digital_rail_select == $past(hwdata[0]))
      && (aux_sel_c.comm_rail_select == $past(hwdata[2]))
      && (aux_sel_c.always_on_reference_select == $past(hwdata[3]));
  endproperty
  a_rails_c: assert property (p_rails_c)
    else $error("rail or always-on select wrong");

  property p_thermistor;
    wr_c |=> aux_sel_c.thermistor_supply_select == $past(hwdata[1]);
  endproperty
  a_thermistor: assert property (p_thermistor)
    else $error("thermistor supply select wrong");

  property p_reserved_zero;
    addr_take && !hwrite && (addr_idx == ADCCE_IDX_CELL
      || addr_idx == ADCCE_IDX_AUX_C) |=> hrdata[31:6] == 26'h000_0000
      && (hrdata[5:4] == 2'h0 || $past(addr_idx) == ADCCE_IDX_CELL);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_hold_no_write;
    !wr_pend_reg |=> $stable({cell_sel, aux_sel_a, aux_sel_b, aux_sel_c});
  endproperty
  a_hold_no_write: assert property (p_hold_no_write)
    else $error("enables changed without a write");

  property p_read_back;
    addr_take && !hwrite && (addr_idx == ADCCE_IDX_AUX_B)
      |=> hrdata == {24'h00_0000, aux_sel_b};
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("aux b read does not match its outputs");

  property p_no_wait;
    hreadyout |=> hreadyout;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("slave inserted a wait state");

  c_cell_all: cover property (wr_cell ##1 cell_sel.convert_on == 6'h3F);
  c_aux_b_read: cover property (wr_b ##1 addr_take && !hwrite
    && addr_idx == ADCCE_IDX_AUX_B);
  c_status_read: cover property (addr_take && !hwrite
    && addr_idx == ADCCE_IDX_STATUS);
  c_back_to_back: cover property (wr_a ##2 wr_b);

endmodule // adcce_regs

/* verification/adcce_regs_tb.sv */
// testbench: channel-enable register bank driven over ahb-lite
`timescale 1ns/10ps
module adc_channel_enable_regs_tb_top;
  import adcce_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = ADCCE_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  adcce_cell_t cell_sel;
  adcce_aux_a_t aux_sel_a;
  adcce_aux_b_t aux_sel_b;
  adcce_aux_c_t aux_sel_c;
  int fails = 0;
  int check_count = 0;
  logic [9:0] idx_tab [4] = '{ADCCE_IDX_CELL, ADCCE_IDX_AUX_A,
    ADCCE_IDX_AUX_B, ADCCE_IDX_AUX_C};
  logic [31:0] mask_tab [4] = '{32'h0000_003F, 32'h0000_00FF,
    32'h0000_00FF, 32'h0000_000F};
  logic [31:0] rd;

  adcce_regs u_adcce_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hready),
    .hrdata(hrdata),
    .hresp(hresp),
    .cell_sel(cell_sel),
    .aux_sel_a(aux_sel_a),
    .aux_sel_b(aux_sel_b),
    .aux_sel_c(aux_sel_c)
  );

  always #12.5 hclk = ~hclk;

  task close_out;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // entered right after a rising edge; single transfer of size sz, waits on hready
  task xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
            input logic [2:0] sz, output logic [31:0] rdat);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= ADCCE_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdat = hrdata;
  endtask

  task wr_reg(input logic [9:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(1'b1, idx, wd, ADCCE_HSIZE_WORD, dummy);
  endtask

  task rd_reg(input logic [9:0] idx, output logic [31:0] rdat);
    xfer(1'b0, idx, 32'h0000_0000, ADCCE_HSIZE_WORD, rdat);
  endtask

  function automatic logic [31:0] port_of(input int r);
    case (r)
      0: port_of = {26'h000_0000, cell_sel.convert_on};
      1: port_of = {24'h00_0000, aux_sel_a};
      2: port_of = {24'h00_0000, aux_sel_b};
      default: port_of = {28'h000_0000, aux_sel_c};
    endcase
  endfunction

  // one-hot walk: output bit and readback match, reserved bits stay zero
  task walk(input int r);
    logic [31:0] exp;
    for (int b = 0; b < 8; b++)
    begin
      exp = (32'h0000_0001 << b) & mask_tab[r];
      wr_reg(idx_tab[r], 32'hFFFF_FF00 | (32'h0000_0001 << b));
      rd_reg(idx_tab[r], rd);
      check(rd, exp);
      check(port_of(r), exp);
      if (r == 0)
        check({26'h000_0000, cell_sel.shifter_on}, exp);
    end
    wr_reg(idx_tab[r], 32'h0000_0000);
    $display("test walk %0d done", r);
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    fails++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int r = 0; r < 4; r++)
    begin
      rd_reg(idx_tab[r], rd);
      check(rd, 32'h0000_0000);
      check(port_of(r), 32'h0000_0000);
    end
    $display("test reset values done");
    walk(0);
    walk(1);
    walk(2);
    walk(3);
    // named fields, back to back write then read
    wr_reg(ADCCE_IDX_AUX_A, 32'h0000_0084);
    wr_reg(ADCCE_IDX_AUX_B, 32'h0000_0060);
    rd_reg(ADCCE_IDX_AUX_B, rd);
    check(rd, 32'h0000_0060);
    check({31'h0, aux_sel_a.aux_pin_four_select}, 32'h0000_0001);
    check({31'h0, aux_sel_a.zero_ref_select}, 32'h0000_0001);
    check({31'h0, aux_sel_a.battery_input_select}, 32'h0000_0000);
    check({31'h0, aux_sel_b.cold_threshold_select}, 32'h0000_0001);
    check({31'h0, aux_sel_b.hot_threshold_select}, 32'h0000_0001);
    $display("test named fields done");
    // non-word write ignored, unmapped place reads zero
    wr_reg(ADCCE_IDX_CELL, 32'h0000_0015);
    xfer(1'b1, ADCCE_IDX_CELL, 32'h0000_003F, 3'h0, rd);
    rd_reg(ADCCE_IDX_CELL, rd);
    check(rd, 32'h0000_0015);
    rd_reg(ADCCE_IDX_STATUS, rd);
    check(rd, 32'h0000_0013);
    wr_reg(10'h10D, 32'hFFFF_FFFF);
    rd_reg(10'h10D, rd);
    check(rd, 32'h0000_0000);
    check({31'h0, hresp}, 32'h0000_0000);
    $display("test refusals done");
    // second reset in mid-run clears every enable
    for (int r = 0; r < 4; r++)
      wr_reg(idx_tab[r], 32'hFFFF_FFFF);
    hresetn <= 1'b0;
    #2;
    for (int r = 0; r < 4; r++)
      check(port_of(r), 32'h0000_0000);
    check({26'h000_0000, cell_sel.shifter_on}, 32'h0000_0000);
    check({31'h0, hready}, 32'h0000_0000);
    check(hrdata, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd_reg(ADCCE_IDX_AUX_B, rd);
    check(rd, 32'h0000_0000);
    $display("test mid-run reset done");
    close_out();
  end
endmodule // adc_channel_enable_regs_tb_top
